/* File: include/timer_pkg.sv */
// Purpose: Shared constants and carrier types for the timer, PWM and timebase unit.
// Assumes: One system clock at 20 MHz; 32768 Hz oscillator arrives as a plain pin.
// Notes: The full-power cycle count is derived here from the printed time and the clock rate.
`default_nettype none
package timer_pkg;

   localparam int NUM_TIMERS = 5;
   localparam int CNT_W = 16;
   localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
   localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
   localparam logic [CNT_W-1:0] PRESET_RESET = 16'h0000;

   // PWM duty limits in 256ths of a period
   localparam int PWM_W = 8;
   localparam logic [PWM_W-1:0] PWM_DUTY_MIN = 8'h01;
   localparam logic [PWM_W-1:0] PWM_DUTY_MAX = 8'hFE;
   localparam logic [PWM_W-1:0] PWM_RESET = 8'h00;

   // Timebase divider: tick n fires when the low TB_DIV_BITS[n] bits are all ones
   localparam int TB_W = 14;
   localparam int TB_NUM = 6;
   localparam int TB_DIV_BITS [TB_NUM] = '{3, 4, 6, 9, 11, 14};
   localparam logic [TB_W-1:0] TB_RESET = 14'h0000;
   localparam logic [2:0] TB_SEL_4K = 3'h0;
   localparam logic [2:0] TB_SEL_2K = 3'h1;
   localparam logic [2:0] TB_SEL_512 = 3'h2;
   localparam logic [2:0] TB_SEL_64 = 3'h3;
   localparam logic [2:0] TB_SEL_16 = 3'h4;
   localparam logic [2:0] TB_SEL_2 = 3'h5;
   localparam int TB_IDX_2HZ = 5;

   // Oscillator full-power window
   localparam longint SYS_CLK_HZ = 20_000_000;
   localparam longint FULL_POWER_TIME_MS = 7500;
   localparam longint FULL_POWER_CYCLES = (FULL_POWER_TIME_MS * SYS_CLK_HZ) / 1000;
   localparam int FP_W = 28;

   typedef struct packed {
      logic run;     // Counter advances every clock
      logic irq_en;  // Overflow may raise a request
   } timer_ctrl_t;

   typedef struct packed {
      logic en;        // Line enabled
      logic [2:0] sel; // Which timebase tick drives it
   } tb_sel_t;

endpackage
`default_nettype wire

/* File: core/reload_counter.sv */
// Purpose: One sixteen-bit auto-reload up-counter with its own preset register.
// Assumes: Preset writes and run come from logic on the same clock.
// Notes: Overflow pulse is registered, one cycle per wrap.
`timescale 1ns/1ps
`default_nettype none
module reload_counter (
   input wire logic ref_clk,                            // System clock
   input wire logic rst_n,                              // Async reset, active low
   input wire logic run,                                // Count enable level
   input wire logic preset_wr,                          // One-cycle preset write strobe
   input wire logic [timer_pkg::CNT_W-1:0] preset_wdata, // Preset write data
   output logic [timer_pkg::CNT_W-1:0] count_q,         // Running count
   output logic [timer_pkg::CNT_W-1:0] preset_q,        // Stored preset
   output logic ovf_q                                   // One-cycle overflow pulse
);

   logic [timer_pkg::CNT_W-1:0] count_d;
   logic wrap;

   // Wrap detect and next count
   assign wrap = run && (count_q == timer_pkg::CNT_MAX);
   always_comb begin
      if (wrap) begin
         count_d = preset_q;
      end else if (run) begin
         count_d = count_q + 16'h0001;
      end else begin
         count_d = count_q;
      end
   end

   // Running count
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         count_q <= timer_pkg::CNT_RESET;
      end else begin
         count_q <= count_d;
      end
   end

   // Preset kept apart so a write never disturbs the live count
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         preset_q <= timer_pkg::PRESET_RESET;
      end else if (preset_wr) begin
         preset_q <= preset_wdata;
      end
   end

   // Overflow pulse
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ovf_q <= 1'b0;
      end else begin
         ovf_q <= wrap;
      end
   end

endmodule // reload_counter
`default_nettype wire

/* File: core/reload_timer_timebase_pwm.sv */
// Purpose: Five reload timers, one duty PWM, oscillator timebase and oscillator power control.
// Assumes: osc_32k_in is the 32768 Hz oscillator as a pin, well below the 20 MHz clock.
// Notes: Interrupt outputs are one-cycle requests; latching belongs to the interrupt controller.
`timescale 1ns/1ps
`default_nettype none
module reload_timer_timebase_pwm #(
   parameter longint FULL_POWER_CYCLES = timer_pkg::FULL_POWER_CYCLES // Full-power window length
) (
   input wire logic ref_clk,                                         // System clock, 20 MHz
   input wire logic rst_n,                                           // Async reset, active low
   input wire timer_pkg::timer_ctrl_t [timer_pkg::NUM_TIMERS-1:0] timer_ctrl, // Per-timer run and enable
   input wire logic [timer_pkg::NUM_TIMERS-1:0] preset_wr,           // Per-timer preset write strobes
   input wire logic [timer_pkg::CNT_W-1:0] preset_wdata,             // Shared preset write data
   output logic [timer_pkg::NUM_TIMERS-1:0][timer_pkg::CNT_W-1:0] timer_count, // Live counts
   output logic [timer_pkg::NUM_TIMERS-1:0][timer_pkg::CNT_W-1:0] timer_preset, // Stored presets
   output logic [timer_pkg::NUM_TIMERS-1:0] timer_irq,               // Overflow requests, pulses
   input wire logic pwm_en,                                          // PWM enable level
   input wire logic [timer_pkg::PWM_W-1:0] pwm_duty,                 // Duty in 256ths
   output logic pwm_out,                                             // PWM pin drive
   input wire logic osc_32k_in,                                      // 32768 Hz oscillator pin
   input wire timer_pkg::tb_sel_t tb_sel_a,                          // Tick choice, line a
   input wire timer_pkg::tb_sel_t tb_sel_b,                          // Tick choice, line b
   output logic timebase_tick_irq_a,                                 // Timebase request, line a
   output logic timebase_tick_irq_b,                                 // Timebase request, line b
   output logic rtc_wake,                                            // Half-second wake pulse
   input wire logic osc_auto_save,                                   // Auto power-saving mode
   output logic osc_low_power                                        // Oscillator low-power select
);

   // ------------------------------------------------------------------
   // Reload timers
   // ------------------------------------------------------------------
   logic [timer_pkg::NUM_TIMERS-1:0] ovf;
   logic [timer_pkg::NUM_TIMERS-1:0] timer_irq_d;

   // One counter per channel, all identical
   genvar gi;
   generate
      for (gi = 0; gi < timer_pkg::NUM_TIMERS; gi++) begin : g_timer
         reload_counter u_cnt (
            .ref_clk(ref_clk),
            .rst_n(rst_n),
            .run(timer_ctrl[gi].run),
            .preset_wr(preset_wr[gi]),
            .preset_wdata(preset_wdata),
            .count_q(timer_count[gi]),
            .preset_q(timer_preset[gi]),
            .ovf_q(ovf[gi])
         );
         // Request gated by its own enable in the cycle after the wrap, while ovf is high
         assign timer_irq_d[gi] = ovf[gi] && timer_ctrl[gi].irq_en;
      end
   endgenerate

   // Registered request so the pin is a clean flop output
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         timer_irq <= '0;
      end else begin
         timer_irq <= timer_irq_d;
      end
   end

   // ------------------------------------------------------------------
   // Duty PWM
   // ------------------------------------------------------------------
   logic [timer_pkg::PWM_W-1:0] pwm_cnt_q;
   logic [timer_pkg::PWM_W-1:0] duty_lim;
   logic [timer_pkg::PWM_W-1:0] duty_q;

   // Out-of-range duty codes are clamped, so the pin never sits flat
   always_comb begin
      if (pwm_duty < timer_pkg::PWM_DUTY_MIN) begin
         duty_lim = timer_pkg::PWM_DUTY_MIN;
      end else if (pwm_duty > timer_pkg::PWM_DUTY_MAX) begin
         duty_lim = timer_pkg::PWM_DUTY_MAX;
      end else begin
         duty_lim = pwm_duty;
      end
   end

   // Period counter, 256 clocks per period
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pwm_cnt_q <= timer_pkg::PWM_RESET;
      end else if (pwm_en) begin
         pwm_cnt_q <= pwm_cnt_q + 8'h01;
      end else begin
         pwm_cnt_q <= timer_pkg::PWM_RESET;
      end
   end

   // Duty taken at period start, and every clock while disabled, avoiding glitched periods
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         duty_q <= timer_pkg::PWM_DUTY_MIN;
      end else if (pwm_cnt_q == 8'hFF || !pwm_en) begin
         duty_q <= duty_lim;
      end
   end

   // Output high for duty_q counts of each period
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pwm_out <= 1'b0;
      end else begin
         pwm_out <= pwm_en && (pwm_cnt_q < duty_q);
      end
   end

   // ------------------------------------------------------------------
   // Oscillator input and timebase divider
   // ------------------------------------------------------------------
   logic osc_sync1_q;
   logic osc_sync2_q;
   logic osc_prev_q;
   logic osc_rise;
   logic [timer_pkg::TB_W-1:0] tb_div_q;
   logic [timer_pkg::TB_NUM-1:0] tb_tick;

   // Two-stage synchroniser; only the second stage is looked at
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         osc_sync1_q <= 1'b0;
         osc_sync2_q <= 1'b0;
         osc_prev_q <= 1'b0;
      end else begin
         osc_sync1_q <= osc_32k_in;
         osc_sync2_q <= osc_sync1_q;
         osc_prev_q <= osc_sync2_q;
      end
   end

   assign osc_rise = osc_sync2_q && !osc_prev_q;

   // Free-running divider, one step per oscillator rising edge
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         tb_div_q <= timer_pkg::TB_RESET;
      end else if (osc_rise) begin
         tb_div_q <= tb_div_q + 14'h0001;
      end
   end

   // Tick n when the low bits roll over: 32768 / 2^bits Hz
   genvar gt;
   generate
      for (gt = 0; gt < timer_pkg::TB_NUM; gt++) begin : g_tick
         assign tb_tick[gt] = osc_rise && (&tb_div_q[timer_pkg::TB_DIV_BITS[gt]-1:0]);
      end
   endgenerate

   // Source selection for one line; unused codes select nothing
   function automatic logic tb_pick(input timer_pkg::tb_sel_t s, input logic [timer_pkg::TB_NUM-1:0] t);
      logic r;
      r = 1'b0;
      if (s.en) begin
         case (s.sel)
            timer_pkg::TB_SEL_4K: r = t[0];
            timer_pkg::TB_SEL_2K: r = t[1];
            timer_pkg::TB_SEL_512: r = t[2];
            timer_pkg::TB_SEL_64: r = t[3];
            timer_pkg::TB_SEL_16: r = t[4];
            timer_pkg::TB_SEL_2: r = t[5];
            default: r = 1'b0;
         endcase
      end
      return r;
   endfunction

   // Timebase requests on the two lines
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         timebase_tick_irq_a <= 1'b0;
         timebase_tick_irq_b <= 1'b0;
      end else begin
         timebase_tick_irq_a <= tb_pick(tb_sel_a, tb_tick);
         timebase_tick_irq_b <= tb_pick(tb_sel_b, tb_tick);
      end
   end

   // Half-second event, always on, used to wake the CPU
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rtc_wake <= 1'b0;
      end else begin
         rtc_wake <= tb_tick[timer_pkg::TB_IDX_2HZ];
      end
   end

   // ------------------------------------------------------------------
   // Oscillator power control
   // ------------------------------------------------------------------
   localparam logic [timer_pkg::FP_W-1:0] FP_LAST = timer_pkg::FP_W'(FULL_POWER_CYCLES - 1);
   logic [timer_pkg::FP_W-1:0] fp_cnt_q;
   logic fp_done_q;

   // Window counted from reset in system clocks; saturates once over
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         fp_cnt_q <= '0;
         fp_done_q <= 1'b0;
      end else if (!fp_done_q) begin
         if (fp_cnt_q == FP_LAST) begin
            fp_done_q <= 1'b1;
         end else begin
            fp_cnt_q <= fp_cnt_q + 28'h0000001;
         end
      end
   end

   // Normal mode never drops power; window runs regardless of mode
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         osc_low_power <= 1'b0;
      end else begin
         osc_low_power <= osc_auto_save && fp_done_q;
      end
   end

endmodule // reload_timer_timebase_pwm
`default_nettype wire

/* File: verif/timer_unit_checker.sv */
// Purpose: Port assertions for the timer, PWM and timebase unit.
// Assumes: One clock domain; timer 0 stands in for all five.
// Notes: Window length comes in as a parameter.
`timescale 1ns/1ps
`default_nettype none
module timer_unit_checker #(
   parameter longint FULL_POWER_CYCLES = timer_pkg::FULL_POWER_CYCLES // Full-power window
) (
   input wire logic ref_clk, // System clock
   input wire logic rst_n, // Async reset
   input wire timer_pkg::timer_ctrl_t [timer_pkg::NUM_TIMERS-1:0] timer_ctrl, // Run and enable
   input wire logic [timer_pkg::NUM_TIMERS-1:0] preset_wr, // Preset strobes
   input wire logic [timer_pkg::CNT_W-1:0] preset_wdata, // Preset data
   input wire logic [timer_pkg::NUM_TIMERS-1:0][timer_pkg::CNT_W-1:0] timer_count, // Counts
   input wire logic [timer_pkg::NUM_TIMERS-1:0][timer_pkg::CNT_W-1:0] timer_preset, // Presets
   input wire logic [timer_pkg::NUM_TIMERS-1:0] timer_irq, // Requests
   input wire logic pwm_en, // PWM enable
   input wire logic pwm_out, // PWM pin
   input wire logic timebase_tick_irq_a, // Tick line a
   input wire logic rtc_wake, // Wake pulse
   input wire logic osc_auto_save, // Auto mode
   input wire logic osc_low_power // Low-power select
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   logic wrap0;
   longint up_q;
   // Timer 0 about to wrap
   assign wrap0 = timer_ctrl[0].run && timer_count[0] == timer_pkg::CNT_MAX;
   // Edges since reset release; low power may not come earlier
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) up_q <= 0;
      else up_q <= up_q + 1;
   end
   count_up_a: assert property (timer_ctrl[0].run && !wrap0 |=> timer_count[0] == $past(timer_count[0]) + 16'h0001)
      else $error("count did not step");
   count_hold_a: assert property (!timer_ctrl[0].run |=> $stable(timer_count[0]))
      else $error("stopped count moved");
   wrap_reload_a: assert property (wrap0 |=> timer_count[0] == $past(timer_preset[0]))
      else $error("no reload on wrap");
   irq_follow_a: assert property (wrap0 ##1 timer_ctrl[0].irq_en |=> timer_irq[0])
      else $error("missing overflow request");
   irq_cause_a: assert property (timer_irq[0] |-> $past(wrap0, 2))
      else $error("request without wrap");
   preset_load_a: assert property (preset_wr[0] |=> timer_preset[0] == $past(preset_wdata))
      else $error("preset not stored");
   preset_hold_a: assert property (!preset_wr[0] |=> $stable(timer_preset[0]))
      else $error("preset changed alone");
   pwm_off_a: assert property (!pwm_en [*2] |-> !pwm_out)
      else $error("pwm high while off");
   tick_gap_a: assert property (timebase_tick_irq_a |=> !timebase_tick_irq_a [*8])
      else $error("ticks too close");
   wake_pulse_a: assert property (rtc_wake |=> !rtc_wake)
      else $error("wake longer than a cycle");
   power_mode_a: assert property (osc_low_power |-> $past(osc_auto_save))
      else $error("low power in normal mode");
   power_window_a: assert property (osc_low_power |-> up_q >= FULL_POWER_CYCLES)
      else $error("low power too early");
endmodule // timer_unit_checker
bind reload_timer_timebase_pwm timer_unit_checker #(.FULL_POWER_CYCLES(FULL_POWER_CYCLES)) i_chk (
   .ref_clk, .rst_n, .timer_ctrl, .preset_wr, .preset_wdata, .timer_count, .timer_preset,
   .timer_irq, .pwm_en, .pwm_out, .timebase_tick_irq_a, .rtc_wake, .osc_auto_save, .osc_low_power);
`default_nettype wire

/* File: verif/reload_timer_timebase_pwm_tb.sv */
// Purpose: Self-checking bench for the timer, PWM and timebase unit.
// Assumes: Oscillator pin toggled by the bench, four clocks a period.
// Notes: Short full-power window keeps the run brief.
`timescale 1ns/1ps
`default_nettype none
module reload_timer_timebase_pwm_tb;
   timer_pkg::timer_ctrl_t [4:0] timer_ctrl = '0;
   logic [4:0] preset_wr = '0;
   logic [15:0] preset_wdata = 16'h0000;
   logic [4:0][15:0] timer_count, timer_preset;
   logic [4:0] timer_irq;
   logic [7:0] pwm_duty = 8'h00;
   logic ref_clk = 1'b0, rst_n = 1'b0, pwm_en = 1'b0, osc = 1'b0, auto_save = 1'b1;
   logic pwm_out, tick_a, tick_b, rtc_wake, low_power;
   logic [15:0] base;
   timer_pkg::tb_sel_t sel_a = '0, sel_b = '0;
   timer_pkg::tb_sel_t seg_b [4] = '{'{1'b1, 3'h6}, '{1'b1, 3'h7}, '{1'b0, 3'h0}, '{1'b1, timer_pkg::TB_SEL_16}};
   logic [7:0] duty_in [5] = '{8'h01, 8'h80, 8'hFE, 8'h00, 8'hFF};
   int duty_exp [5] = '{1, 128, 254, 1, 254};
   int seg_a [4] = '{64, 32, 8, 1};
   int seg_bx [4] = '{0, 0, 0, 1};
   int errors = 0, samples_checked = 0, na = 0, nb = 0, nr = 0, hi, n0, n1, guard;
   int nt [5] = '{default: 0};
   // 20 MHz system clock
   always #25 ref_clk = ~ref_clk;
   reload_timer_timebase_pwm #(.FULL_POWER_CYCLES(50)) i_dut (
      .ref_clk, .rst_n, .timer_ctrl, .preset_wr, .preset_wdata, .timer_count, .timer_preset,
      .timer_irq, .pwm_en, .pwm_duty, .pwm_out, .osc_32k_in(osc), .tb_sel_a(sel_a), .tb_sel_b(sel_b),
      .timebase_tick_irq_a(tick_a), .timebase_tick_irq_b(tick_b), .rtc_wake,
      .osc_auto_save(auto_save), .osc_low_power(low_power));
   // Tally pulses; an unknown counts as none and shows as a shortfall
   always @(posedge ref_clk) begin
      na <= na + int'(tick_a);
      nb <= nb + int'(tick_b);
      nr <= nr + int'(rtc_wake);
      for (int i = 0; i < 5; i++) nt[i] <= nt[i] + int'(timer_irq[i]);
   end
   task automatic chk_val(input logic [15:0] got, input logic [15:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic chk_cnt(input int got, input int exp, input string what);
      chk_val(16'(got), 16'(exp), what);
   endtask
   task automatic wait_clk(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   // Rising edges on the oscillator pin, two clocks high and two low
   task automatic osc_edges(input int n);
      repeat (n) begin
         repeat (2) @(posedge ref_clk);
         osc <= 1'b1;
         repeat (2) @(posedge ref_clk);
         osc <= 1'b0;
      end
   endtask
   task automatic test_done;
      $display("errors %0d samples_checked %0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      wait_clk(40);
      for (int i = 0; i < 5; i++) chk_val(timer_count[i], 16'h0000, "count after reset");
      chk_val(low_power, 16'h0000, "power early");
      wait_clk(20);
      chk_val(low_power, 16'h0001, "power late");
      @(posedge ref_clk);
      auto_save <= 1'b0;
      wait_clk(3);
      chk_val(low_power, 16'h0000, "normal mode");
      foreach (duty_in[k]) begin
         @(posedge ref_clk);
         pwm_en <= 1'b0;
         pwm_duty <= duty_in[k];
         wait_clk(3);
         chk_val(pwm_out, 16'h0000, "pwm off");
         @(posedge ref_clk);
         pwm_en <= 1'b1;
         wait_clk(300);
         hi = 0;
         repeat (256) begin
            wait_clk(1);
            hi += int'(pwm_out);
         end
         chk_cnt(hi, duty_exp[k], "pwm high clocks");
      end
      @(posedge ref_clk);
      sel_a <= '{1'b1, timer_pkg::TB_SEL_4K};
      sel_b <= '{1'b1, timer_pkg::TB_SEL_2};
      for (int i = 0; i < 5; i++) timer_ctrl[i] <= '{1'b1, 1'(i < 4)};
      fork
         osc_edges(16384);
         begin
            wait_clk(100);
            base = timer_count[0];
            @(posedge ref_clk);
            preset_wr <= '1;
            preset_wdata <= 16'hFFF0;
            @(posedge ref_clk);
            preset_wr <= '0;
            #1;
            chk_val(timer_count[0], base + 16'h0002, "count after preset write");
            for (int i = 0; i < 5; i++) chk_val(timer_preset[i], 16'hFFF0, "preset");
            guard = 0;
            while (timer_count[0] !== 16'hFFFF && guard < 70000) begin
               wait_clk(1);
               guard++;
            end
            wait_clk(1);
            for (int i = 0; i < 5; i++) chk_val(timer_count[i], 16'hFFF0, "reload");
            wait_clk(52);
            for (int i = 0; i < 5; i++) chk_cnt(nt[i], (i < 4) ? 4 : 0, "overflow requests");
         end
      join
      wait_clk(8);
      chk_cnt(na, 2048, "fast ticks");
      chk_cnt(nb, 1, "slow ticks");
      chk_cnt(nr, 1, "wake pulses");
      for (int s = 0; s < 4; s++) begin
         @(posedge ref_clk);
         sel_a <= '{1'b1, 3'(s)};
         sel_b <= seg_b[s];
         n0 = na;
         n1 = nb;
         osc_edges(512);
         wait_clk(8);
         chk_cnt(na - n0, seg_a[s], "line a ticks");
         chk_cnt(nb - n1, seg_bx[s], "line b ticks");
      end
      test_done;
   end
   // Watchdog: the whole run needs about 77000 clocks
   initial begin
      repeat (90000) @(posedge ref_clk);
      errors++;
      $display("wrong value at %0t: watchdog expired", $time);
      test_done;
   end
endmodule // reload_timer_timebase_pwm_tb
`default_nettype wire
